// file: pkg/lusp_pkg.sv
// Package of constants, types and register map for the UDP sample packetizer.
package lusp_pkg;

   // Register indices on the plain register port (word addresses).
   localparam logic [3:0] REG_CTRL     = 4'h0;
   localparam logic [3:0] REG_PORT     = 4'h1;
   localparam logic [3:0] REG_HOSTIP   = 4'h2;
   localparam logic [3:0] REG_RATE     = 4'h3;
   localparam logic [3:0] REG_STATUS   = 4'h4;
   localparam logic [3:0] REG_IRQSTAT  = 4'h5;
   localparam logic [3:0] REG_IRQMASK  = 4'h6;
   localparam logic [3:0] REG_PKTCNT   = 4'h7;

   // Control register field positions.
   localparam int CTRL_START_BIT  = 0;
   localparam int CTRL_LITTLE_BIT = 1;
   localparam int CTRL_CKSUM_BIT  = 2;
   localparam int CTRL_CONT_LSB   = 4;
   localparam int CTRL_LEN_LSB    = 8;

   // Reset values.
   localparam logic [15:0] PORT_RESET = 16'h0749;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

   // Header field positions.
   localparam int HDR_CNT_LSB  = 0;
   localparam int HDR_CONT_LSB = 8;
   localparam int HDR_LEN_LSB  = 12;
   localparam int HDR_RATE_LSB = 16;
   localparam int HDR_OVL_BIT  = 24;
   localparam int HDR_ERR_BIT  = 25;
   localparam int HDR_LE_BIT   = 28;
   localparam int HDR_CK_BIT   = 29;

   // Payload sizes in bytes per length code.
   localparam logic [10:0] LEN_BYTES_0 = 11'd1024;
   localparam int          HDR_BYTES   = 4;
   localparam logic [4:0]  RATE_MAX    = 5'd31;

   // Clocks per base sample period: 250 MHz down to 1.25 MHz.
   localparam logic [7:0]  BASE_DIV    = 8'd200;

   // Interrupt status bits.
   localparam int IRQ_PKT_DONE = 0;
   localparam int IRQ_DROP     = 1;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_HDR  = 2'b01,
      ST_DATA = 2'b10
   } lusp_state_e;

   typedef struct packed {
      logic [31:0] x;
      logic [31:0] y;
      logic [31:0] r;
      logic [31:0] th;
   } lusp_sample_s;

   typedef struct packed {
      logic [7:0] data;
      logic       first;
      logic       last;
   } lusp_byte_s;

   typedef struct packed {
      logic inOvl;
      logic syncOvl;
      logic syncOn;
      logic outOvl;
      logic pllUnlock;
      logic syncRange;
   } lusp_cond_s;

endpackage

// file: design/lusp_byte_sel.sv
// Byte selector: picks one byte of a word in big or little-endian order.
`timescale 1ns/1ps
module lusp_byte_sel (
   // Word and position
   input  wire logic [31:0] word,
   input  wire logic [1:0]  idx,
   input  wire logic        isInt,
   input  wire logic        little,
   // Selected byte
   output      logic [7:0]  byteOut
);
   logic [1:0] pos;

   // Big-endian sends MSB first; little reverses bytes within each word.
   always_comb begin
      if (isInt) begin
         // 16-bit word sits in low half: big is B1 B0, little B0 B1.
         pos = little ? {1'b0, idx[0]} : {1'b0, ~idx[0]};  // [RQ4] [RQ5]
      end else begin
         pos = little ? idx : ~idx;                        // [RQ4] [RQ5]
      end
      byteOut = word[pos*8 +: 8];
   end
endmodule

// file: design/lusp_rate_div.sv
// Sample tick generator: base 1.25 MHz divided by two to the power N.
`timescale 1ns/1ps
module lusp_rate_div (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       arst_n,
   // Rate code
   input  wire logic [4:0] rateN,
   // Tick
   output      logic       tick
);
   import lusp_pkg::*;
   logic [7:0]  baseCnt_q;
   logic [30:0] subCnt_q;
   logic        baseTick;

   assign baseTick = (baseCnt_q == BASE_DIV - 8'd1);
   assign tick = baseTick && ((subCnt_q & ((31'd1 << rateN) - 31'd1)) == '0);

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         baseCnt_q <= 8'h00;
      end else begin
         baseCnt_q <= baseTick ? 8'h00 : baseCnt_q + 8'd1;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         subCnt_q <= 31'h0;
      end else if (baseTick) begin
         subCnt_q <= subCnt_q + 31'd1;
      end
   end
endmodule

// file: design/lusp_packetizer.sv
// UDP sample packetizer: frames lock-in samples behind a 32-bit header.
// Behaviour
// (RQ1) Packets go to the host address that issued the start command.
// (RQ2) Destination port defaults to 1865 unless reprogrammed.
// (RQ3) Packet is 4-byte header plus 128 to 1024 payload bytes.
// (RQ4) Big-endian sends words and halfwords most significant byte first.
// (RQ5) Little-endian reverses bytes within each word, never bits.
// (RQ6) Header is always sent big-endian.
// (RQ7) With checksum on, an errored packet is dropped whole.
// (RQ8) Header bits 7:0 count packets modulo 256.
// (RQ9) Header bits 11:8 give content code, floats 0-3, integers 4-7.
// (RQ10) Header bits 15:12 give length code 0..3 for 1024..128 bytes.
// (RQ11) Header bits 23:16 hold rate exponent N, 0 to 31.
// (RQ12) Bit 24 flags overload existing at packet start.
// (RQ13) Bit 25 flags unlock or sync out-of-range at packet start.
// (RQ14) Bit 28 is one for little-endian payload.
// (RQ15) Bit 29 is one when checksumming is enabled.
// (RQ16) Payload interleaves X, Y, R, theta per sample, unselected dropped.
// (RQ17) Receiver swaps floats by four bytes and integers by two.
// (RQ18) Host should choose small packets at low rates.
// (RQ19) Header bits 26, 27, 30, 31 are always zero.
//
// Local design decisions: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module lusp_packetizer (
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 arst_n,
   // Register port
   input  wire logic [3:0]           regAddr,
   input  wire logic [31:0]          regWdata,
   input  wire logic                 regWr,
   input  wire logic                 regRd,
   output      logic [31:0]          regRdata,
   // Sample input and status conditions
   input  wire lusp_pkg::lusp_sample_s sample,
   input  wire lusp_pkg::lusp_cond_s   cond,
   // Command source address
   input  wire logic [31:0]          cmdSrcIp,
   // Outgoing byte stream
   output      lusp_pkg::lusp_byte_s txByte,
   output      logic                 txValid,
   input  wire logic                 txReady,
   output      logic [31:0]          txDstIp,
   output      logic [15:0]          txDstPort,
   output      logic                 txCksumEn,
   input  wire logic                 txErr,
   output      logic                 txDrop,
   // Interrupt
   output      logic                 irq
);
   import lusp_pkg::*;

   logic [31:0]  ctrl_q;
   logic [15:0]  port_q;
   logic [31:0]  hostIp_q;
   logic [4:0]   rate_q;
   logic [1:0]   irqStat_q;
   logic [1:0]   irqMask_q;
   logic [7:0]   pktCnt_q;
   logic [31:0]  hdr_q;
   lusp_state_e  state_q;
   logic [10:0]  byteCnt_q;
   logic [10:0]  payLen_q;
   logic [1:0]   chan_q;
   logic [1:0]   bIdx_q;
   logic [31:0]  word_q;
   lusp_sample_s hold_q;
   logic         pend_q;
   logic         errSeen_q;
   logic         tick;
   logic [7:0]   selByte;
   logic         isInt;
   logic [3:0]   chanMask;
   logic [1:0]   wordBytes;
   logic         xfer;
   logic         lastByte;
   logic         pktDone;
   logic [2:0]   content;
   logic [1:0]   lenCode;
   logic         started;

   function automatic logic [3:0] chan_mask(input logic [1:0] c);
      case (c)
         2'd0:    chan_mask = 4'b0001;
         2'd1:    chan_mask = 4'b0011;
         2'd2:    chan_mask = 4'b1100;
         default: chan_mask = 4'b1111;
      endcase
   endfunction

   function automatic logic [1:0] next_chan(input logic [3:0] m,
                                            input logic [1:0] c);
      logic [1:0] n;
      n = c;
      // Lowest selected channel above c, or c itself when c ends a sample.
      for (int i = 3; i >= 1; i--) begin
         if (i > int'(c) && m[i]) begin
            n = 2'(i);
         end
      end
      next_chan = n;
   endfunction

   function automatic logic [1:0] first_chan(input logic [3:0] m);
      first_chan = m[0] ? 2'd0 : 2'd2;
   endfunction

   assign started   = ctrl_q[CTRL_START_BIT];
   assign content   = ctrl_q[CTRL_CONT_LSB +: 3];
   assign lenCode   = ctrl_q[CTRL_LEN_LSB +: 2];
   assign isInt     = content[2];
   assign chanMask  = chan_mask(content[1:0]);
   assign wordBytes = isInt ? 2'd1 : 2'd3;
   assign xfer      = txValid && txReady;
   assign lastByte  = (state_q == ST_DATA) && (byteCnt_q == payLen_q - 11'd1);
   assign pktDone   = xfer && lastByte;

   lusp_rate_div uRate (
      .clk    (clk),
      .arst_n (arst_n),
      .rateN  (rate_q),
      .tick   (tick)
   );

   lusp_byte_sel uSel (
      .word    (state_q == ST_HDR ? hdr_q : word_q),
      .idx     (bIdx_q),
      .isInt   (state_q == ST_HDR ? 1'b0 : isInt),
      .little  (state_q == ST_HDR ? 1'b0 : ctrl_q[CTRL_LITTLE_BIT]), // [RQ6]
      .byteOut (selByte)
   );

   // Register writes.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_q    <= CTRL_RESET;
         port_q    <= PORT_RESET;                                  // [RQ2]
         hostIp_q  <= 32'h0;
         rate_q    <= 5'h0;
         irqMask_q <= 2'h0;
      end else if (regWr) begin
         case (regAddr)
            REG_CTRL: begin
               ctrl_q <= regWdata;
               if (regWdata[CTRL_START_BIT] && !started) begin
                  hostIp_q <= cmdSrcIp;                            // [RQ1]
               end
            end
            REG_PORT:    port_q    <= regWdata[15:0];              // [RQ2]
            REG_RATE:    rate_q    <= (regWdata[4:0] > RATE_MAX) ?
                                      RATE_MAX : regWdata[4:0];    // [RQ11]
            REG_IRQMASK: irqMask_q <= regWdata[1:0];
            default: ;
         endcase
      end
   end

   // Interrupt status: hardware set wins over write-one-to-clear.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         irqStat_q <= 2'h0;
      end else begin
         irqStat_q <= (irqStat_q & ~((regWr && regAddr == REG_IRQSTAT) ?
                       regWdata[1:0] : 2'h0))
                    | {txDrop, pktDone && !txDrop};
      end
   end
   assign irq = |(irqStat_q & irqMask_q);

   // Read data, valid the cycle after the strobe.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         regRdata <= 32'h0;
      end else if (regRd) begin
         case (regAddr)
            REG_CTRL:    regRdata <= ctrl_q;
            REG_PORT:    regRdata <= {16'h0, port_q};
            REG_HOSTIP:  regRdata <= hostIp_q;
            REG_RATE:    regRdata <= {27'h0, rate_q};
            REG_STATUS:  regRdata <= {29'h0, state_q, pend_q};
            REG_IRQSTAT: regRdata <= {30'h0, irqStat_q};
            REG_IRQMASK: regRdata <= {30'h0, irqMask_q};
            REG_PKTCNT:  regRdata <= {24'h0, pktCnt_q};
            default:     regRdata <= 32'h0;
         endcase
      end else begin
         regRdata <= 32'h0;
      end
   end

   // Sample capture: latest sample waits until the stream takes it.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         hold_q <= '0;
         pend_q <= 1'b0;
      end else if (tick && started) begin
         hold_q <= sample;
         pend_q <= 1'b1;
      end else if (xfer && state_q == ST_DATA && bIdx_q == wordBytes &&
                   chan_q == next_chan(chanMask, chan_q)) begin
         pend_q <= 1'b0;
      end
   end

   // Packet framing state machine.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q   <= ST_IDLE;
         hdr_q     <= 32'h0;
         byteCnt_q <= 11'h0;
         payLen_q  <= LEN_BYTES_0;
         bIdx_q    <= 2'h0;
         chan_q    <= 2'h0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (started && pend_q) begin
                  hdr_q <= '0;                                     // [RQ19]
                  hdr_q[HDR_CNT_LSB  +: 8] <= pktCnt_q;            // [RQ8]
                  hdr_q[HDR_CONT_LSB +: 4] <= {1'b0, content};     // [RQ9]
                  hdr_q[HDR_LEN_LSB  +: 4] <= {2'b00, lenCode};    // [RQ10]
                  hdr_q[HDR_RATE_LSB +: 8] <= {3'b000, rate_q};    // [RQ11]
                  hdr_q[HDR_OVL_BIT] <= cond.inOvl ||
                     (cond.syncOn && cond.syncOvl) ||
                     (isInt && cond.outOvl);                       // [RQ12]
                  hdr_q[HDR_ERR_BIT] <= cond.pllUnlock ||
                     cond.syncRange;                               // [RQ13]
                  hdr_q[HDR_LE_BIT] <= ctrl_q[CTRL_LITTLE_BIT];    // [RQ14]
                  hdr_q[HDR_CK_BIT] <= ctrl_q[CTRL_CKSUM_BIT];     // [RQ15]
                  payLen_q <= LEN_BYTES_0 >> lenCode;              // [RQ3]
                  bIdx_q   <= 2'h0;
                  state_q  <= ST_HDR;
               end
            end
            ST_HDR: begin
               if (xfer) begin
                  bIdx_q <= bIdx_q + 2'd1;
                  if (bIdx_q == 2'd3) begin                        // [RQ3]
                     state_q   <= ST_DATA;
                     byteCnt_q <= 11'h0;
                     chan_q    <= first_chan(chanMask);
                     bIdx_q    <= 2'h0;
                  end
               end
            end
            ST_DATA: begin
               if (xfer) begin
                  byteCnt_q <= byteCnt_q + 11'd1;
                  bIdx_q    <= (bIdx_q == wordBytes) ? 2'h0 : bIdx_q + 2'd1;
                  if (bIdx_q == wordBytes) begin
                     chan_q <= (next_chan(chanMask, chan_q) == chan_q) ?
                               first_chan(chanMask) :
                               next_chan(chanMask, chan_q);        // [RQ16]
                  end
                  if (lastByte) begin
                     state_q <= ST_IDLE;
                  end
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // Channel word for the current byte, integers in the low half.
   always_comb begin
      case (chan_q)
         2'd0:    word_q = hold_q.x;
         2'd1:    word_q = hold_q.y;
         2'd2:    word_q = hold_q.r;
         default: word_q = hold_q.th;
      endcase
   end

   // Packet counter advances once per packet sent.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pktCnt_q <= 8'h00;
      end else if (pktDone) begin
         pktCnt_q <= pktCnt_q + 8'd1;                              // [RQ8]
      end
   end

   // Any error seen during a checked packet drops it whole at the end.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         errSeen_q <= 1'b0;
      end else if (state_q == ST_IDLE) begin
         errSeen_q <= 1'b0;
      end else if (txErr && ctrl_q[CTRL_CKSUM_BIT]) begin
         errSeen_q <= 1'b1;                                        // [RQ7]
      end
   end
   assign txDrop = pktDone && ctrl_q[CTRL_CKSUM_BIT] &&
                   (errSeen_q || txErr);                           // [RQ7]

   assign txValid      = (state_q == ST_HDR) ||
                         (state_q == ST_DATA && pend_q);
   assign txByte.data  = selByte;
   assign txByte.first = (state_q == ST_HDR) && (bIdx_q == 2'd0);
   assign txByte.last  = lastByte;
   assign txDstIp      = hostIp_q;                                 // [RQ1]
   assign txDstPort    = port_q;                                   // [RQ2]
   assign txCksumEn    = ctrl_q[CTRL_CKSUM_BIT];                   // [RQ7]

   a_hdr_zero_bits: assert property (@(posedge clk) disable iff (!arst_n)
      state_q == ST_HDR |-> hdr_q[27:26] == 2'b00 && hdr_q[31:30] == 2'b00)
      else $error("reserved header bits not zero"); // [RQ19]
   a_hdr_le_flag: assert property (@(posedge clk) disable iff (!arst_n)
      state_q == ST_HDR |-> hdr_q[HDR_LE_BIT] == ctrl_q[CTRL_LITTLE_BIT])
      else $error("little-end flag wrong"); // [RQ14]
   a_hdr_ck_flag: assert property (@(posedge clk) disable iff (!arst_n)
      state_q == ST_HDR |-> hdr_q[HDR_CK_BIT] == ctrl_q[CTRL_CKSUM_BIT])
      else $error("checksum flag wrong"); // [RQ15]
   a_pkt_count_step: assert property (@(posedge clk) disable iff (!arst_n)
      pktDone |=> pktCnt_q == $past(pktCnt_q) + 8'd1)
      else $error("packet counter did not step"); // [RQ8]
   a_hdr_first_byte: assert property (@(posedge clk) disable iff (!arst_n)
      txByte.first |-> txByte.data == hdr_q[31:24])
      else $error("header not big-endian"); // [RQ6]
   a_pay_len_code: assert property (@(posedge clk) disable iff (!arst_n)
      state_q == ST_DATA |-> payLen_q == (LEN_BYTES_0 >> hdr_q[13:12]))
      else $error("payload length mismatch"); // [RQ10]
   a_drop_needs_ck: assert property (@(posedge clk) disable iff (!arst_n)
      txDrop |-> ctrl_q[CTRL_CKSUM_BIT] && lastByte)
      else $error("drop outside checked packet end"); // [RQ7]
   a_dst_port_held: assert property (@(posedge clk) disable iff (!arst_n)
      !(regWr && regAddr == REG_PORT) |=> txDstPort == $past(txDstPort))
      else $error("port changed without write"); // [RQ2]
   a_rate_range: assert property (@(posedge clk) disable iff (!arst_n)
      state_q == ST_HDR |-> hdr_q[23:21] == 3'b000)
      else $error("rate code above 31"); // [RQ11]
   a_hdr_four_bytes: assert property (@(posedge clk) disable iff (!arst_n)
      state_q == ST_HDR && xfer && bIdx_q == 2'd3 |=> state_q == ST_DATA)
      else $error("header not four bytes"); // [RQ3]

   c_packet_done: cover property (@(posedge clk) disable iff (!arst_n)
      pktDone);
   c_packet_drop: cover property (@(posedge clk) disable iff (!arst_n)
      txDrop);
   c_little_pkt: cover property (@(posedge clk) disable iff (!arst_n)
      pktDone && ctrl_q[CTRL_LITTLE_BIT]);
endmodule

// file: testbench/lusp_host_model.sv
// Receiving host model: collects whole packets from the outgoing byte stream.
`timescale 1ns/1ps
module lusp_host_model
   import lusp_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       arst_n,
   // Byte stream from the device
   input  wire lusp_byte_s txByte,
   input  wire logic       txValid,
   output      logic       txReady,
   input  wire logic       txDrop,
   // Stall request from the bench
   input  wire logic       slow
);
   logic [7:0] cur[$];
   logic [7:0] pkt[$];
   logic       pktDrop = 1'b0;
   int         pktCount = 0;
   logic       stallQ;

   // While slow is set the host drops txReady on every other cycle.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         stallQ <= 1'b0;
      end else begin
         stallQ <= slow & ~stallQ;
      end
   end
   assign txReady = ~stallQ;

   // A packet is handed on only once its last byte arrived.
   always @(posedge clk) begin
      if (arst_n && txValid && txReady) begin
         if (txByte.first) begin
            cur.delete();
         end
         cur.push_back(txByte.data);
         if (txByte.last) begin
            pkt = cur;
            pktDrop = txDrop;
            pktCount++;
         end
      end
   end
endmodule

// file: testbench/tb_top.sv
// Self-checking testbench for the UDP sample packetizer.
`timescale 1ns/1ps
`define CHK(act, exp) chk(32'(act), 32'(exp))
module tb_top;
   import lusp_pkg::*;
   // Per code: inOvl syncOvl syncOn outOvl pllUnlock syncRange.
   localparam logic [5:0] COND_TAB [8] = '{6'h20, 6'h00, 6'h04, 6'h10,
                                          6'h01, 6'h02, 6'h04, 6'h18};
   logic         clk;
   logic         arst_n;
   logic [3:0]   regAddr;
   logic [31:0]  regWdata;
   logic         regWr;
   logic         regRd;
   logic [31:0]  regRdata;
   lusp_sample_s sample;
   lusp_cond_s   cond;
   logic [31:0]  cmdSrcIp;
   lusp_byte_s   txByte;
   logic         txValid;
   logic         txReady;
   logic [31:0]  txDstIp;
   logic [15:0]  txDstPort;
   logic         txCksumEn;
   logic         txErr;
   logic         txDrop;
   logic         irq;
   logic         slow;
   int           bad_count = 0;
   int           num_checks = 0;

   lusp_packetizer i_dut (
      .clk(clk), .arst_n(arst_n), .regAddr(regAddr), .regWdata(regWdata),
      .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .sample(sample),
      .cond(cond), .cmdSrcIp(cmdSrcIp), .txByte(txByte), .txValid(txValid),
      .txReady(txReady), .txDstIp(txDstIp), .txDstPort(txDstPort),
      .txCksumEn(txCksumEn), .txErr(txErr), .txDrop(txDrop), .irq(irq)
   );

   lusp_host_model i_host (
      .clk(clk), .arst_n(arst_n), .txByte(txByte), .txValid(txValid),
      .txReady(txReady), .txDrop(txDrop), .slow(slow)
   );

   always #2 clk = ~clk;

   task automatic chk(input logic [31:0] a, input logic [31:0] e);
      num_checks++;
      if (a !== e) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, a, e);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge clk);
      regWr <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRd <= 1'b0;
      #1 d = regRdata;
   endtask

   task automatic wait_pkt();
      int n0;
      n0 = i_host.pktCount;
      for (int i = 0; i < 20000 && i_host.pktCount == n0; i++) begin
         @(posedge clk);
      end
      #1;
      `CHK(i_host.pktCount, n0 + 1);
   endtask

   task automatic irq_is(input logic e);
      repeat (2) @(posedge clk);
      #1 `CHK(irq, e);
   endtask

   // Little-endian payload reverses bytes within one channel word only.
   function automatic logic [7:0] exp_byte(input logic [2:0] code,
                                           input int j);
      int bps;
      int nch;
      int ch;
      int k;
      logic [31:0] w;
      bps = code[2] ? 2 : 4;
      nch = (code[1:0] == 2'h0) ? 1 : ((code[1:0] == 2'h3) ? 4 : 2);
      ch = (j / bps) % nch + ((code[1:0] == 2'h2) ? 2 : 0);
      w = (ch == 0) ? sample.x : (ch == 1) ? sample.y :
          (ch == 2) ? sample.r : sample.th;
      k = j % bps;
      if (!code[0]) begin
         k = bps - 1 - k;
      end
      return w[8 * k +: 8];
   endfunction

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   initial begin
      repeat (90000) @(posedge clk);
      bad_count++;
      $display("wrong value at %0t: watchdog expired", $time);
      tally_and_finish();
   end

   initial begin
      logic [31:0] d;
      logic [31:0] hdr;
      logic [2:0]  code;
      logic [5:0]  t;
      bit          found;
      clk = 1'b0;
      arst_n = 1'b0;
      regAddr = 4'h0;
      regWdata = 32'h0;
      regWr = 1'b0;
      regRd = 1'b0;
      cond = '0;
      cmdSrcIp = 32'h0;
      txErr = 1'b0;
      slow = 1'b0;
      sample = '{x: 32'h1122_3344, y: 32'h5566_7788, r: 32'h99aa_bbcc,
                 th: 32'hddee_ff01};
      repeat (20) @(posedge clk);
      arst_n <= 1'b1;
      rd(REG_PORT, d);
      `CHK(d, 32'h0000_0749);
      `CHK(txDstPort, 16'h0749);
      rd(4'hf, d);
      `CHK(d, 32'h0);
      wr(REG_RATE, 32'h3f);
      rd(REG_RATE, d);
      `CHK(d, 32'h1f);
      $display("test registers done");
      for (int c = 0; c < 8; c++) begin
         code = 3'(c);
         t = COND_TAB[c];
         cond <= lusp_cond_s'(t);
         txErr <= code[1];
         slow <= code[0];
         cmdSrcIp <= 32'hc0a8_0100 + 32'(c);
         wr(REG_RATE, {31'h0, code == 3'h3});
         wr(REG_CTRL, {22'h0, 2'h3, 1'b0, code, 1'b0, code[0], code[0],
                       1'b1});
         found = 1'b0;
         for (int a = 0; a < 3 && !found; a++) begin
            wait_pkt();
            hdr = {i_host.pkt[0], i_host.pkt[1], i_host.pkt[2],
                   i_host.pkt[3]};
            found = hdr[15:8] == {4'h3, 1'b0, code};
         end
         `CHK(found, 1'b1);
         `CHK(i_host.pkt.size(), 132);
         `CHK(hdr[7:0], 8'(i_host.pktCount - 1));
         `CHK(hdr[23:16], {7'h0, code == 3'h3});
         `CHK(hdr[24], t[5] | (t[4] & t[3]) | (t[2] & code[2]));
         `CHK(hdr[25], t[1] | t[0]);
         `CHK({hdr[31:30], hdr[27:26]}, 4'h0);
         `CHK(hdr[29:28], {code[0], code[0]});
         `CHK(txCksumEn, code[0]);
         `CHK(txDstIp, 32'hc0a8_0100 + 32'(c));
         `CHK(i_host.pktDrop, code[0] & code[1]);
         for (int j = 0; j < 128; j++) begin
            `CHK(i_host.pkt[4 + j], exp_byte(code, j));
         end
         wr(REG_CTRL, 32'h0);
         $display("test content code %0d done", c);
      end
      txErr <= 1'b0;
      repeat (5000) @(posedge clk);
      rd(REG_IRQSTAT, d);
      `CHK(d[1:0], 2'h3);
      wr(REG_IRQMASK, 32'h2);
      irq_is(1'b1);
      wr(REG_IRQSTAT, 32'h2);
      irq_is(1'b0);
      rd(REG_IRQSTAT, d);
      `CHK(d[1:0], 2'h1);
      wr(REG_IRQMASK, 32'h1);
      irq_is(1'b1);
      wr(REG_IRQSTAT, 32'h1);
      irq_is(1'b0);
      $display("test interrupts done");
      rd(REG_PKTCNT, d);
      `CHK(d, 32'(8'(i_host.pktCount)));
      wr(REG_PORT, 32'h0000_1234);
      #1 `CHK(txDstPort, 16'h1234);
      wr(REG_HOSTIP, 32'h0);
      rd(REG_HOSTIP, d);
      `CHK(d, 32'hc0a8_0107);
      $display("test port and host address done");
      tally_and_finish();
   end
endmodule
